/* logic/dma_burst_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts
 * for the burst transfer control block; included by module and testbench.
 */
`ifndef DMA_BURST_REGS_SVH
`define DMA_BURST_REGS_SVH

// register word addresses (plain port, 4-bit address)
`define REG_CTRL 4'h0
`define REG_CNT0 4'h1
`define REG_CNT1 4'h2
`define REG_STAT 4'h3
`define REG_MASK 4'h4
`define REG_DTCE 4'h5
`define REG_STATE 4'h6

// control register fields
`define CTRL_IE0_BIT 0
`define CTRL_BURST0_BIT 1
`define CTRL_IE1_BIT 2
`define CTRL_BURST1_BIT 3
`define CTRL_ME0_BIT 4
`define CTRL_ME1_BIT 5
`define CTRL_RESET 8'h00

// transfer-complete event vector numbers
`define VEC_EVENT_BASE 8'h48
`define VEC_EVENT_LAST 8'h4B

// bus cycle phases of one transfer, in system clocks
`define READ_CYCLES 2
`define WRITE_CYCLES 2
`define DEAD_CYCLES 1

`endif

/* logic/dma_burst_pkg.sv */
/*
 * types shared by the burst transfer control block.
 * assumes the constants header sits in the same folder.
 */
package dma_burst_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_DEAD
    } burst_state_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        burst_state_t st;
        logic ch;
        logic [1:0] ph;
        logic last;
        logic nmi_stop;
        logic [7:0] ctrl;
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [3:0] dtce;
        logic [15:0] rdata;
        logic [15:0] data;
        logic nmi_s1;
        logic nmi_s2;
        logic nmi_s3;
        logic [1:0] req_s1;
        logic [1:0] req_s2;
        logic transfer_end_output;
    } dma_state_t;
endpackage

/* logic/dma_burst_transfer_control.sv */
/*
 * two-channel burst transfer engine with transfer-end interrupts and
 * two transfer-complete events (bits 0 and 2 of four) routed to the data transfer controller.
 * assumes a single-master system bus that grants immediately and returns
 * read data in the cycle after a read request; nmi and dreq are pins.
 */
// What this block does
// - control bit 2 enables channel 1 transfer-end interrupt; reset value 0.
// - control bit 0 enables channel 0 transfer-end interrupt; reset value 0.
// - burst mode runs transfers back to back holding the bus until done.
// - final transfer inserts one dead bus state after the write cycle.
// - higher-priority request waits until the running burst completes.
// - nmi during enabled burst channel clears its master enable.
// - active burst finishes current transfer, releases bus, then suspends.
// - last transfer already started completes despite cleared master enable.
// - two transfer-complete events driven, ch0 on bit 0 (vector 72) and ch1 on bit 2 (vector 74), each dtc-gated.
`timescale 1ns/1ps
`include "dma_burst_regs.svh"

module dma_burst_transfer_control
    import dma_burst_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic i_clk_sys, // 50 mhz system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic [3:0] i_addr, // register word address
    input wire logic [15:0] i_wdata, // register write data
    input wire logic i_wr, // register write strobe
    input wire logic i_rd, // register read strobe
    output logic [15:0] o_rdata, // register read data, cycle after strobe
    input wire logic i_nmi, // non-maskable interrupt pin
    input wire logic [1:0] i_dreq, // transfer request pins, ch0 highest
    output bus_req_t o_bus, // system bus request
    input wire logic [15:0] i_bus_rdata, // system bus read data
    output logic o_bus_hold, // bus held by this block
    output logic o_transfer_end_output, // high during final transfer
    output logic o_irq, // level interrupt, unmasked status set
    output logic [3:0] o_xfer_complete_event, // one-cycle events, only 72 (bit 0) and 74 (bit 2) driven
    output logic [3:0] o_dtc_trigger, // events gated to the dtc
    output logic [7:0] o_vector // vector of highest event pulsing this cycle, 72 when none
);
    localparam logic [1:0] RD_N = 2'(`READ_CYCLES - 1);
    localparam logic [1:0] WR_N = 2'(`WRITE_CYCLES - 1);

    dma_state_t s_q;
    dma_state_t s_d;
    logic [3:0] ev;
    logic [3:0] set_st;
    logic [15:0] cur_cnt;
    logic bursting;
    logic [3:0] clr;

    always_comb begin
        cur_cnt = s_q.ch ? s_q.cnt1 : s_q.cnt0;
        bursting = s_q.st != ST_IDLE;
    end

    always_comb begin
        s_d = s_q;
        ev = 4'h0;
        clr = 4'h0;
        s_d.nmi_s1 = i_nmi;
        s_d.nmi_s2 = s_q.nmi_s1;
        s_d.nmi_s3 = s_q.nmi_s2;
        s_d.req_s1 = i_dreq;
        s_d.req_s2 = s_q.req_s1;
        s_d.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `REG_CTRL: s_d.rdata = {8'h00, s_q.ctrl};
                `REG_CNT0: s_d.rdata = s_q.cnt0;
                `REG_CNT1: s_d.rdata = s_q.cnt1;
                `REG_STAT: s_d.rdata = {12'h000, s_q.stat};
                `REG_MASK: s_d.rdata = {12'h000, s_q.mask};
                `REG_DTCE: s_d.rdata = {12'h000, s_q.dtce};
                `REG_STATE: s_d.rdata = {12'h000, s_q.nmi_stop,
                                         s_q.ch, bursting, s_q.last};
                default: s_d.rdata = 16'h0000;
            endcase
        end
        if (i_wr) begin
            case (i_addr)
                `REG_CTRL: s_d.ctrl = i_wdata[7:0];
                `REG_CNT0: s_d.cnt0 = i_wdata;
                `REG_CNT1: s_d.cnt1 = i_wdata;
                `REG_STAT: clr = i_wdata[3:0];
                `REG_MASK: s_d.mask = i_wdata[3:0];
                `REG_DTCE: s_d.dtce = i_wdata[3:0];
                default: ;
            endcase
        end
        // rising nmi drops master enable of burst channels
        if (s_q.nmi_s2 && !s_q.nmi_s3) begin
            if (s_q.ctrl[`CTRL_BURST0_BIT]) begin
                s_d.ctrl[`CTRL_ME0_BIT] = 1'b0;
            end
            if (s_q.ctrl[`CTRL_BURST1_BIT]) begin
                s_d.ctrl[`CTRL_ME1_BIT] = 1'b0;
            end
            if (bursting && !s_q.last) begin
                s_d.nmi_stop = 1'b1;
            end
        end
        case (s_q.st)
            ST_IDLE: begin
                s_d.nmi_stop = 1'b0;
                s_d.ph = 2'd0;
                // ch0 wins only when idle; no pre-emption once started
                if (s_q.ctrl[`CTRL_ME0_BIT] && s_q.req_s2[0]
                        && s_q.cnt0 != 16'h0000) begin
                    s_d.ch = 1'b0;
                    s_d.st = ST_READ;
                    s_d.last = s_q.cnt0 == 16'h0001;
                end else if (s_q.ctrl[`CTRL_ME1_BIT] && s_q.req_s2[1]
                        && s_q.cnt1 != 16'h0000) begin
                    s_d.ch = 1'b1;
                    s_d.st = ST_READ;
                    s_d.last = s_q.cnt1 == 16'h0001;
                end
            end
            ST_READ: begin
                s_d.ph = s_q.ph + 2'd1;
                if (s_q.ph == RD_N) begin
                    s_d.ph = 2'd0;
                    s_d.data = i_bus_rdata;
                    s_d.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                s_d.ph = s_q.ph + 2'd1;
                if (s_q.ph == WR_N) begin
                    s_d.ph = 2'd0;
                    if (s_q.ch) begin
                        s_d.cnt1 = s_q.cnt1 - 16'h0001;
                    end else begin
                        s_d.cnt0 = s_q.cnt0 - 16'h0001;
                    end
                    if (s_q.last) begin
                        s_d.st = ST_DEAD;
                    // an nmi edge in this very cycle stops the burst too
                    end else if (s_d.nmi_stop) begin
                        s_d.st = ST_IDLE;
                    end else begin
                        s_d.st = ST_READ;
                        s_d.last = cur_cnt == 16'h0002;
                    end
                end
            end
            ST_DEAD: begin
                s_d.st = ST_IDLE;
                s_d.last = 1'b0;
                ev[{s_q.ch, 1'b0}] = 1'b1;
            end
            default: s_d.st = ST_IDLE;
        endcase
        // only enabled channels post their transfer-end status
        set_st = ev & {1'b0, s_q.ctrl[`CTRL_IE1_BIT],
                       1'b0, s_q.ctrl[`CTRL_IE0_BIT]};
        s_d.stat = (s_q.stat & ~clr) | set_st;
        s_d.transfer_end_output = s_d.st != ST_IDLE && s_d.last;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_rdata = s_q.rdata;
        o_bus.req = s_q.st == ST_READ || s_q.st == ST_WRITE;
        o_bus.wr = s_q.st == ST_WRITE;
        o_bus.addr = {15'h0000, s_q.ch};
        o_bus.wdata = s_q.data;
        o_bus_hold = bursting;
        o_transfer_end_output = s_q.transfer_end_output;
        o_irq = |(s_q.stat & s_q.mask);
        o_xfer_complete_event = ev;
        o_dtc_trigger = ev & s_q.dtce;
        o_vector = `VEC_EVENT_BASE;
        // later bits win, though only one event can pulse at a time
        if (ev[1]) begin
            o_vector = `VEC_EVENT_BASE + 8'h01;
        end
        if (ev[2]) begin
            o_vector = `VEC_EVENT_BASE + 8'h02;
        end
        if (ev[3]) begin
            o_vector = `VEC_EVENT_LAST;
        end
    end

    a_ie_gate_ch0: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        ev[0] && !s_q.ctrl[`CTRL_IE0_BIT]
        |=> s_q.stat[0] == $past(s_q.stat[0]))
        else $error("ch0 status set while its enable is low");
    a_ie_gate_ch1: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        ev[2] && s_q.ctrl[`CTRL_IE1_BIT] |=> s_q.stat[2])
        else $error("ch1 status not set on enabled end");
    a_burst_hold: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_WRITE && s_d.st == ST_READ |=> o_bus_hold)
        else $error("bus released between burst transfers");
    a_dead_cycle: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_DEAD |-> !o_bus.req ##1 s_q.st == ST_IDLE)
        else $error("dead state not single idle bus state");
    a_no_preempt: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        bursting && s_q.ch |=> s_q.ch || s_q.st == ST_IDLE)
        else $error("burst pre-empted by other channel");
    a_nmi_clear: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_s2 && !s_q.nmi_s3 && s_q.ctrl[`CTRL_BURST0_BIT]
        |=> !s_q.ctrl[`CTRL_ME0_BIT])
        else $error("nmi did not clear master enable");
    a_nmi_suspend: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_stop && s_q.st == ST_READ |-> ##[1:4] s_q.st == ST_IDLE)
        else $error("burst not suspended after nmi");
    a_last_finish: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.last && s_q.st == ST_READ |-> ##[1:5] s_q.st == ST_DEAD)
        else $error("last transfer not completed");
    a_event_dtc: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        o_dtc_trigger != 4'h0
        |-> (o_dtc_trigger & ~o_xfer_complete_event) == 4'h0)
        else $error("dtc trigger without event");
    a_irq_sticky: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.stat[0] && !(i_wr && i_addr == `REG_STAT && i_wdata[0])
        |=> s_q.stat[0])
        else $error("status dropped without clear");

    a_ie1_block: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        ev[2] && !s_q.ctrl[`CTRL_IE1_BIT] |=> s_q.stat[2] == $past(s_q.stat[2]))
        else $error("ch1 status set while its enable is low");
    a_ie0_post: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        ev[0] && s_q.ctrl[`CTRL_IE0_BIT] |=> s_q.stat[0])
        else $error("ch0 status not set on enabled end");
    a_burst_bus_req: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_READ || s_q.st == ST_WRITE |-> o_bus.req && o_bus_hold)
        else $error("bus not requested inside a transfer");
    a_read_len: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_READ && s_q.ph == 2'd0 |=> s_q.st == ST_READ)
        else $error("read phase cut short");
    a_write_len: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_WRITE && s_q.ph == 2'd0 |=> s_q.st == ST_WRITE)
        else $error("write phase cut short");
    a_write_follows: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_READ && s_q.ph == RD_N |=> s_q.st == ST_WRITE)
        else $error("read not followed by write");
    a_count_down0: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_WRITE && s_q.ph == WR_N && !s_q.ch && !i_wr
        |=> s_q.cnt0 == $past(s_q.cnt0) - 16'h0001)
        else $error("ch0 count not decremented per write");
    a_count_down1: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_WRITE && s_q.ph == WR_N && s_q.ch && !i_wr
        |=> s_q.cnt1 == $past(s_q.cnt1) - 16'h0001)
        else $error("ch1 count not decremented per write");

    a_dead_no_write: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_DEAD |-> o_bus_hold && !o_bus.wr)
        else $error("dead state released bus or wrote");
    a_dead_after_last: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_WRITE && s_q.ph == WR_N && s_q.last |=> s_q.st == ST_DEAD)
        else $error("final write not followed by dead state");
    a_transfer_end_output_in_burst: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        o_transfer_end_output |-> bursting)
        else $error("transfer end flag outside a burst");
    a_no_switch: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        bursting && $changed(s_q.ch) |-> $past(s_q.st) == ST_IDLE)
        else $error("channel switched inside a burst");
    a_nmi_clear_ch1: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_s2 && !s_q.nmi_s3 && s_q.ctrl[`CTRL_BURST1_BIT]
        |=> !s_q.ctrl[`CTRL_ME1_BIT])
        else $error("nmi did not clear ch1 master enable");

    a_nmi_stop_set: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_s2 && !s_q.nmi_s3 && bursting && !s_q.last |=> s_q.nmi_stop)
        else $error("nmi did not mark the burst for suspension");
    a_nmi_to_idle: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_stop && s_q.st == ST_WRITE && s_q.ph == WR_N && !s_q.last
        |=> s_q.st == ST_IDLE)
        else $error("suspended burst started another transfer");
    a_nmi_no_event: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.nmi_stop |-> ev == 4'h0)
        else $error("suspended burst raised an event");
    a_idle_no_req: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.st == ST_IDLE |-> !o_bus.req && !o_bus_hold)
        else $error("bus held while idle");
    a_last_keeps: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.last && s_q.st == ST_READ |=> bursting)
        else $error("final transfer abandoned");

    a_event_onehot: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        $onehot0(o_xfer_complete_event))
        else $error("more than one event in a cycle");
    a_event_in_dead: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        o_xfer_complete_event != 4'h0 |-> s_q.st == ST_DEAD)
        else $error("event outside the dead state");
    a_vector_ch1: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        o_xfer_complete_event[2] |-> o_vector == `VEC_EVENT_BASE + 8'h02)
        else $error("wrong vector for ch1 event");
    a_dtc_off: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.dtce == 4'h0 |-> o_dtc_trigger == 4'h0)
        else $error("dtc triggered while not enabled");
    a_irq_clear: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        s_q.stat[2] && i_wr && i_addr == `REG_STAT && i_wdata[2] && !ev[2]
        |=> !s_q.stat[2])
        else $error("ch1 status not cleared by write one");

    c_burst_end: cover property (@(posedge i_clk_sys) s_q.st == ST_DEAD);
    c_nmi_stop: cover property (@(posedge i_clk_sys)
        s_q.nmi_stop && s_q.st == ST_IDLE);
    c_irq: cover property (@(posedge i_clk_sys) o_irq);
    c_preempt_wait: cover property (@(posedge i_clk_sys)
        bursting && s_q.ch && s_q.req_s2[0]);
    c_dtc_fire: cover property (@(posedge i_clk_sys) o_dtc_trigger != 4'h0);
endmodule

/* testbench/sys_mem_model.sv */
/*
 * behavioural memory on the system bus behind the burst engine.
 * assumes read data is expected in the cycle after a read request.
 */
`timescale 1ns/1ps

module sys_mem_model
    import dma_burst_pkg::*;
(
    input wire logic i_clk_sys, // system clock
    input wire bus_req_t i_bus, // request from the engine
    output logic [15:0] o_rdata // read data, cycle after request
);
    // released data lines toggle so a stale value never looks valid
    always_ff @(posedge i_clk_sys) begin
        if (i_bus.req && !i_bus.wr) begin
            o_rdata <= i_bus.addr ^ 16'ha5a5;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

/* testbench/tb_top.sv */
/*
 * self-checking bench for the burst transfer control block.
 * assumes the memory model answers every bus read in the cycle after the request.
 */
`timescale 1ns/1ps
`include "dma_burst_regs.svh"

module tb_top
    import dma_burst_pkg::*;
;
    localparam logic [15:0] B0 = 16'h0001 << `CTRL_BURST0_BIT;
    localparam logic [15:0] B1 = 16'h0001 << `CTRL_BURST1_BIT;
    localparam logic [15:0] M0 = 16'h0001 << `CTRL_ME0_BIT;
    localparam logic [15:0] M1 = 16'h0001 << `CTRL_ME1_BIT;
    localparam logic [15:0] E0 = 16'h0001 << `CTRL_IE0_BIT;
    localparam int XFER = `READ_CYCLES + `WRITE_CYCLES;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, nmi = 0;
    logic [3:0] addr = 0;
    logic [15:0] wdata = 0, rdata, bus_rdata, d, w;
    logic [1:0] dreq = 0;
    bus_req_t bus;
    logic hold, transfer_end_output, irq;
    logic [3:0] ev, dtc, e, t;
    logic [7:0] vec, v;
    int failures = 0, checks = 0, n, m, cyc = 0;

    dma_burst_transfer_control u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_nmi(nmi), .i_dreq(dreq), .o_bus(bus),
        .i_bus_rdata(bus_rdata), .o_bus_hold(hold),
        .o_transfer_end_output(transfer_end_output), .o_irq(irq),
        .o_xfer_complete_event(ev), .o_dtc_trigger(dtc), .o_vector(vec));
    sys_mem_model u_mem (.i_clk_sys(clk), .i_bus(bus), .o_rdata(bus_rdata));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= w;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [15:0] r);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        r = rdata;
    endtask

    // one held-bus period: its length, the events and the vector seen
    task automatic run();
        int k;
        k = 0;
        n = 0;
        m = 0;
        w = 0;
        e = 0;
        t = 0;
        v = 0;
        while (hold !== 1'b1 && k < 50) begin
            @(posedge clk);
            #1;
            k++;
        end
        while (hold === 1'b1 && k < 200) begin
            e |= ev;
            t |= dtc;
            if (ev !== 4'h0) v = vec;
            if (transfer_end_output === 1'b1) m++;
            if (bus.wr === 1'b1) w = bus.wdata;
            n++;
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 200) failures++;
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rreg(`REG_CTRL, d); chk(d, 16'h0000);
        wreg(4'hf, 16'hffff);
        rreg(4'hf, d); chk(d, 16'h0000);
        wreg(`REG_DTCE, 16'h0001);
        wreg(`REG_CNT0, 16'h0002);
        wreg(`REG_CTRL, M0 | B0 | E0);
        @(posedge clk) dreq <= 2'b01;
        run();
        chk(n, 2 * XFER + `DEAD_CYCLES);
        chk(e, 4'h1);
        chk(t, 4'h1);
        chk(v, `VEC_EVENT_BASE);
        chk(m, XFER + `DEAD_CYCLES);
        chk(w, 16'ha5a5);
        @(posedge clk) dreq <= 2'b00;
        rreg(`REG_STAT, d); chk(d, 16'h0001);
        chk(irq, 1'b0);
        wreg(`REG_MASK, 16'h0001);
        chk(irq, 1'b1);
        wreg(`REG_STAT, 16'h0001);
        chk(irq, 1'b0);
        // ch1 runs first with its interrupt off; ch0 asks mid-burst
        wreg(`REG_CNT0, 16'h0002);
        wreg(`REG_CNT1, 16'h0002);
        wreg(`REG_CTRL, M0 | M1 | B0 | B1 | E0);
        @(posedge clk) dreq <= 2'b10;
        fork
            run();
            begin
                repeat (4) @(posedge clk);
                dreq <= 2'b11;
            end
        join
        chk(n, 2 * XFER + `DEAD_CYCLES);
        chk(w, 16'ha5a4);
        chk(e, 4'h4);
        chk(t, 4'h0);
        chk(v, `VEC_EVENT_BASE + 8'h02);
        run();
        chk(e, 4'h1);
        @(posedge clk) dreq <= 2'b00;
        rreg(`REG_STAT, d); chk(d, 16'h0001);
        wreg(`REG_STAT, 16'h000f);
        // nmi lands inside a four-word burst
        wreg(`REG_CNT0, 16'h0004);
        wreg(`REG_CTRL, M0 | B0);
        @(posedge clk) dreq <= 2'b01;
        fork
            run();
            begin
                repeat (7) @(posedge clk);
                nmi <= 1;
                repeat (4) @(posedge clk);
                nmi <= 0;
            end
        join
        @(posedge clk) dreq <= 2'b00;
        chk(n % XFER, 0);
        chk(n < 4 * XFER, 1'b1);
        chk(e, 4'h0);
        rreg(`REG_CTRL, d); chk(d, B0);
        rreg(`REG_CNT0, d); chk(d, 16'(4 - n / XFER));
        stop_test();
    end
endmodule
